// File: beam_permit_logic.sv
// Overview of operation
// - Permit rises only when all inputs agree and at least one destination requests beam; any fault drops it.
// - A withdrawn destination request gates beam to that destination only.
// - A dropped destination permit interrupts all linac beam.
// - Beam at the first accelerating structure stops within 10 us of a drop.
// - Loss above 500 uA averaged over a sliding 1 us window drops the permit.
// - In continuous wave mode, loss above 5 uA over 1/60 s drops the permit.
// - A 30 us average above expected plus max(20 %, 20 uA) drops the permit.
// - The first step turns off the chopper within 10 us of the drop.
// - Current still seen 15 us after the drop switches the source off.
// - Severe inputs trigger both steps at once.
// - Failed inputs are captured at the drop; latching ones need a reset.
// - Self-recovering inputs restore the permit after a set delay.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module beam_permit_logic #(
  parameter int NUM_IN = 16,
  parameter int NUM_DEST = 4,
  parameter int CUR_W = 16,
  parameter int MAINS_CYC = beam_permit_pkg::MAINS_CYC_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire beam_permit_pkg::axil_req_s axiReq,
  output beam_permit_pkg::axil_rsp_s axiRsp,
  input wire logic [NUM_IN-1:0] inputOk,
  input wire logic [NUM_DEST-1:0] destRequest,
  input wire logic [NUM_DEST-1:0] destPermit,
  input wire logic monitorAboveLevel,
  input wire logic [CUR_W-1:0] currentUp,
  input wire logic [CUR_W-1:0] currentDown,
  output logic beamPermit,
  output logic chopperEnable,
  output logic sourceModulatorEnable,
  output logic transportDipoleEnable,
  output logic sourceBiasEnable,
  output logic [NUM_DEST-1:0] destBeamEnable
);
  import beam_permit_pkg::*;

  localparam int FW = NUM_IN + NUM_DEST + 3;
  localparam int LOSS_W = CUR_W + $clog2(LOSS_WIN_CYC) + 1;
  localparam int PAT_W = CUR_W + $clog2(PATTERN_WIN_CYC) + 1;
  localparam int MC_W = $clog2(MAINS_CYC);
  localparam int ACC_W = CUR_W + MC_W + 1;
  localparam int SHUT_W = $clog2(SHUT_WAIT_CYC);
  localparam logic [LOSS_W-1:0] LOSS_SUM_LIMIT =
    LOSS_W'(LOSS_LIMIT_UA * LOSS_WIN_CYC);
  localparam logic [ACC_W-1:0] MAINS_SUM_LIMIT =
    ACC_W'(longint'(MAINS_LIMIT_UA) * longint'(MAINS_CYC));
  localparam logic [MC_W-1:0] MAINS_LAST = MC_W'(MAINS_CYC - 1);
  localparam logic [SHUT_W-1:0] SHUT_LAST = SHUT_W'(SHUT_WAIT_CYC - 1);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic awHeld, wHeld, bValid, rValid, cwMode, opReset;
  logic next_awHeld, next_wHeld, next_bValid, next_rValid, next_cwMode;
  logic next_opReset;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData, rData, next_rData;
  logic [3:0] wStrb, next_wStrb;
  logic [1:0] bResp, next_bResp, rResp, next_rResp;
  logic [NUM_IN-1:0] recoverMask, next_recoverMask;
  logic [NUM_IN-1:0] severeMask, next_severeMask;
  logic [31:0] recoverDelay, next_recoverDelay;
  logic [CUR_W-1:0] expected, next_expected;
  logic [FW-1:0] capture, next_capture;
  logic [31:0] statusWord;
  logic doWrite;
  logic [7:0] rAddr;
  logic lossFault, patternFault, mainsFault;
  permit_state_e state, next_state;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  always_comb begin
    axiRsp.awready = !awHeld;
    axiRsp.wready = !wHeld;
    axiRsp.bvalid = bValid;
    axiRsp.bresp = bResp;
    axiRsp.arready = !rValid;
    axiRsp.rvalid = rValid;
    axiRsp.rdata = rData;
    axiRsp.rresp = rResp;
    statusWord = '0;
    statusWord[ST_PERMIT_BIT] = beamPermit;
    statusWord[ST_CHOPPER_BIT] = chopperEnable;
    statusWord[ST_SOURCE_BIT] = sourceBiasEnable;
    statusWord[ST_LOSS_BIT] = lossFault;
    statusWord[ST_MAINS_BIT] = mainsFault;
    statusWord[ST_PATTERN_BIT] = patternFault;
    statusWord[ST_SHUT_BIT] = (state == ST_SHUT);
    doWrite = awHeld && wHeld && !bValid;
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid && !axiReq.bready;
    next_bResp = bResp;
    next_rValid = rValid && !axiReq.rready;
    next_rData = rData;
    next_rResp = rResp;
    next_cwMode = cwMode;
    next_opReset = 1'b0;
    next_recoverMask = recoverMask;
    next_severeMask = severeMask;
    next_recoverDelay = recoverDelay;
    next_expected = expected;
    if (axiReq.awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = axiReq.awaddr[ADDR_MSB:0];
    end
    if (axiReq.wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = axiReq.wdata;
      next_wStrb = axiReq.wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = RESP_OKAY;
      case ({awAddr[ADDR_MSB:ADDR_LSB], 2'h0})
        REG_CTRL: begin
          if (wStrb[0]) begin
            next_cwMode = wData[CTRL_CW_BIT];
            next_opReset = wData[CTRL_RESET_BIT];
          end
        end
        REG_RECOVER_MASK: next_recoverMask = NUM_IN'(merge(
          32'(recoverMask), wData, wStrb));
        REG_SEVERE_MASK: next_severeMask = NUM_IN'(merge(
          32'(severeMask), wData, wStrb));
        REG_RECOVER_DELAY: next_recoverDelay = merge(recoverDelay, wData,
          wStrb);
        REG_EXPECTED: next_expected = CUR_W'(merge(32'(expected), wData,
          wStrb));
        REG_STATUS, REG_CAPTURE: next_bResp = RESP_OKAY;
        default: next_bResp = RESP_SLVERR;
      endcase
    end
    rAddr = {axiReq.araddr[ADDR_MSB:ADDR_LSB], 2'h0};
    if (axiReq.arvalid && !rValid) begin
      next_rValid = 1'b1;
      next_rResp = RESP_OKAY;
      case (rAddr)
        REG_CTRL: next_rData = 32'(cwMode);
        REG_RECOVER_MASK: next_rData = 32'(recoverMask);
        REG_SEVERE_MASK: next_rData = 32'(severeMask);
        REG_RECOVER_DELAY: next_rData = recoverDelay;
        REG_EXPECTED: next_rData = 32'(expected);
        REG_STATUS: next_rData = statusWord;
        REG_CAPTURE: next_rData = 32'(capture);
        default: begin
          next_rData = '0;
          next_rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
      bValid <= 1'b0;
      bResp <= RESP_OKAY;
      rValid <= 1'b0;
      rData <= '0;
      rResp <= RESP_OKAY;
      cwMode <= 1'b0;
      opReset <= 1'b0;
      recoverMask <= '0;
      severeMask <= '0;
      recoverDelay <= RECOVER_DELAY_RESET;
      expected <= '0;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
      cwMode <= next_cwMode;
      opReset <= next_opReset;
      recoverMask <= next_recoverMask;
      severeMask <= next_severeMask;
      recoverDelay <= next_recoverDelay;
      expected <= next_expected;
    end
  end

  // ----------------------------------------------------------------
  // Current comparison
  // ----------------------------------------------------------------
  logic [CUR_W-1:0] loss;
  logic [LOSS_W-1:0] lossSum;
  logic [PAT_W-1:0] patSum;
  logic [47:0] patThr, patLimit;
  logic [MC_W-1:0] mainsCnt, next_mainsCnt;
  logic [ACC_W-1:0] mainsAcc, next_mainsAcc;
  logic next_mainsFault;

  // Negative difference means no loss, not a wrap to a huge value
  assign loss = (currentUp > currentDown) ? currentUp - currentDown : '0;

  sliding_sum #(.WIDTH(CUR_W), .DEPTH(LOSS_WIN_CYC), .SUM_W(LOSS_W))
    lossWin (.sys_clk(sys_clk), .srst(srst), .sample(loss),
             .sum(lossSum));
  sliding_sum #(.WIDTH(CUR_W), .DEPTH(PATTERN_WIN_CYC), .SUM_W(PAT_W))
    patWin (.sys_clk(sys_clk), .srst(srst), .sample(currentDown),
            .sum(patSum));

  always_comb begin
    lossFault = lossSum > LOSS_SUM_LIMIT;
    patThr = 48'(expected) * 48'(PATTERN_PCT) / 48'(PCT_DIV);
    if (patThr < 48'(PATTERN_FLOOR_UA)) begin
      patThr = 48'(PATTERN_FLOOR_UA);
    end
    patLimit = (48'(expected) + patThr) * 48'(PATTERN_WIN_CYC);
    patternFault = 48'(patSum) > patLimit;
    // One mains period, integrate and dump, no sample memory needed
    next_mainsCnt = (mainsCnt == MAINS_LAST) ? '0 : mainsCnt + 1'b1;
    next_mainsAcc = mainsAcc + ACC_W'(loss);
    next_mainsFault = 1'b0;
    if (mainsCnt == MAINS_LAST) begin
      next_mainsAcc = '0;
      next_mainsFault = cwMode && (mainsAcc + ACC_W'(loss) >
        MAINS_SUM_LIMIT);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mainsCnt <= '0;
      mainsAcc <= '0;
      mainsFault <= 1'b0;
    end else begin
      mainsCnt <= next_mainsCnt;
      mainsAcc <= next_mainsAcc;
      mainsFault <= next_mainsFault;
    end
  end

  // ----------------------------------------------------------------
  // Fault latching and permit sequencing
  // ----------------------------------------------------------------
  logic [FW-1:0] rawFault, latched, next_latched, recMaskFull, clearMask;
  logic [31:0] recTimer, next_recTimer;
  logic [SHUT_W-1:0] shutCnt, next_shutCnt;
  logic faultFree, anyReq, severe, recoverDone;
  logic next_beamPermit, next_sourceOn;
  logic [NUM_DEST-1:0] next_destBeamEnable;

  always_comb begin
    // Healthy is high, so a dead or floating-low line reads as alarm
    rawFault = {mainsFault, patternFault, lossFault, ~destPermit,
                ~inputOk};
    recMaskFull = {{(FW - NUM_IN){1'b0}}, recoverMask};
    severe = |(~inputOk & severeMask);
    recoverDone = (recTimer >= recoverDelay);
    next_recTimer = '0;
    if ((latched != '0) && ((latched & ~recMaskFull) == '0) &&
        (rawFault == '0) && (state != ST_SHUT) && !recoverDone) begin
      next_recTimer = recTimer + 1'b1;
    end
    clearMask = '0;
    if (opReset) begin
      clearMask = '1;
    end else if ((latched != '0) && (rawFault == '0) && recoverDone &&
                 ((latched & ~recMaskFull) == '0)) begin
      clearMask = recMaskFull;
    end
    // New faults win over a clear in the same cycle
    next_latched = (latched & ~clearMask) | rawFault;
    faultFree = (latched == '0) && (rawFault == '0);
    anyReq = |destRequest;
    next_state = state;
    next_shutCnt = '0;
    next_capture = capture;
    case (state)
      ST_OFF: begin
        if (faultFree && anyReq) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (!faultFree) begin
          next_capture = rawFault | latched;
          next_state = ST_CHOP;
        end else if (!anyReq) begin
          next_state = ST_OFF;
        end
      end
      ST_CHOP: begin
        next_shutCnt = shutCnt + 1'b1;
        if (shutCnt == SHUT_LAST) begin
          next_state = monitorAboveLevel ? ST_SHUT : ST_OFF;
        end
      end
      ST_SHUT: begin
        if (opReset) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (severe && (state != ST_SHUT)) begin
      if (state == ST_ON) begin
        next_capture = rawFault | latched;
      end
      next_state = ST_SHUT;
    end
    next_beamPermit = (next_state == ST_ON);
    next_sourceOn = (next_state != ST_SHUT);
    next_destBeamEnable = next_beamPermit ? destRequest : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_OFF;
      latched <= '0;
      recTimer <= '0;
      shutCnt <= '0;
      capture <= '0;
      beamPermit <= 1'b0;
      chopperEnable <= 1'b0;
      sourceModulatorEnable <= 1'b0;
      transportDipoleEnable <= 1'b0;
      sourceBiasEnable <= 1'b0;
      destBeamEnable <= '0;
    end else begin
      state <= next_state;
      latched <= next_latched;
      recTimer <= next_recTimer;
      shutCnt <= next_shutCnt;
      capture <= next_capture;
      beamPermit <= next_beamPermit;
      chopperEnable <= next_beamPermit;
      sourceModulatorEnable <= next_sourceOn;
      transportDipoleEnable <= next_sourceOn;
      sourceBiasEnable <= next_sourceOn;
      destBeamEnable <= next_destBeamEnable;
    end
  end
endmodule : beam_permit_logic
`default_nettype wire

// File: beam_permit_pkg.sv
`default_nettype none
package beam_permit_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int LOSS_WIN_NS = 1000;
  localparam int PATTERN_WIN_NS = 30000;
  localparam int SHUT_WAIT_NS = 15000;
  localparam int MAINS_HZ = 60;
  localparam int LOSS_WIN_CYC = LOSS_WIN_NS * CLK_MHZ / 1000;
  localparam int PATTERN_WIN_CYC = PATTERN_WIN_NS * CLK_MHZ / 1000;
  localparam int SHUT_WAIT_CYC = (SHUT_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int MAINS_CYC_DEFAULT = CLK_MHZ * 1000000 / MAINS_HZ;

  // ----------------------------------------------------------------
  // Limits, all currents in microamps
  // ----------------------------------------------------------------
  localparam int LOSS_LIMIT_UA = 500;
  localparam int MAINS_LIMIT_UA = 5;
  localparam int PATTERN_PCT = 20;
  localparam int PCT_DIV = 100;
  localparam int PATTERN_FLOOR_UA = 20;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RECOVER_MASK = 8'h04;
  localparam logic [7:0] REG_SEVERE_MASK = 8'h08;
  localparam logic [7:0] REG_RECOVER_DELAY = 8'h0c;
  localparam logic [7:0] REG_EXPECTED = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CAPTURE = 8'h18;
  localparam int CTRL_CW_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int ST_PERMIT_BIT = 0;
  localparam int ST_CHOPPER_BIT = 1;
  localparam int ST_SOURCE_BIT = 2;
  localparam int ST_LOSS_BIT = 3;
  localparam int ST_MAINS_BIT = 4;
  localparam int ST_PATTERN_BIT = 5;
  localparam int ST_SHUT_BIT = 6;
  localparam logic [31:0] RECOVER_DELAY_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_CHOP, ST_SHUT} permit_state_e;
endpackage : beam_permit_pkg
`default_nettype wire

// File: sliding_sum.sv
`timescale 1ns/1ns
`default_nettype none
module sliding_sum #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 25,
  parameter int SUM_W = WIDTH + $clog2(DEPTH) + 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] sample,
  output logic [SUM_W-1:0] sum
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  // ----------------------------------------------------------------
  // History, not reset: old slots count as zero until first wrap
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] hist [DEPTH];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic filled;
  logic next_filled;
  logic [SUM_W-1:0] next_sum;
  logic [WIDTH-1:0] oldest;

  always_comb begin
    oldest = filled ? hist[ptr] : '0;
    next_sum = sum + SUM_W'(sample) - SUM_W'(oldest);
    next_ptr = (ptr == LAST) ? '0 : ptr + 1'b1;
    next_filled = filled | (ptr == LAST);
  end

  always_ff @(posedge sys_clk) begin
    hist[ptr] <= sample;
    if (srst) begin
      ptr <= '0;
      filled <= 1'b0;
      sum <= '0;
    end else begin
      ptr <= next_ptr;
      filled <= next_filled;
      sum <= next_sum;
    end
  end
endmodule : sliding_sum
`default_nettype wire

// File: beam_permit_logic_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module beam_permit_logic_asserts #(
  parameter int NUM_IN = 16,
  parameter int NUM_DEST = 4,
  parameter int CUR_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [NUM_IN-1:0] inputOk,
  input wire logic [NUM_DEST-1:0] destRequest,
  input wire logic [NUM_DEST-1:0] destPermit,
  input wire logic monitorAboveLevel,
  input wire logic [CUR_W-1:0] currentUp,
  input wire logic [CUR_W-1:0] currentDown,
  input wire logic beamPermit,
  input wire logic chopperEnable,
  input wire logic sourceModulatorEnable,
  input wire logic transportDipoleEnable,
  input wire logic sourceBiasEnable,
  input wire logic [NUM_DEST-1:0] destBeamEnable
);
  import beam_permit_pkg::*;
  // ------
  // Run counters
  // ------
  logic [9:0] lossRun;
  logic [9:0] next_lossRun;
  logic [9:0] stuckRun;
  logic [9:0] next_stuckRun;
  // Small currents only, so the sum never wraps
  always_comb begin
    next_lossRun = 10'h000;
    next_stuckRun = 10'h000;
    if (currentUp > currentDown + CUR_W'(LOSS_LIMIT_UA) && !(&lossRun))
      next_lossRun = lossRun + 10'h001;
    if (!beamPermit && monitorAboveLevel && sourceBiasEnable && !(&stuckRun))
      next_stuckRun = stuckRun + 10'h001;
  end
  always_ff @(posedge sys_clk) begin
    lossRun <= srst ? 10'h000 : next_lossRun;
    stuckRun <= srst ? 10'h000 : next_stuckRun;
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  AST_FAULT_DROP: assert property (
    !(&inputOk) |=> !beamPermit && !chopperEnable)
    else $error("Permit kept with a failed input");
  AST_DEST_DROP: assert property (
    !(&destPermit) |=> !beamPermit && destBeamEnable == '0)
    else $error("Beam kept after a destination drop");
  AST_RISE_ALL: assert property (
    $rose(beamPermit) |-> $past(&inputOk) && $past(&destPermit)
      && $past(|destRequest))
    else $error("Permit rose without all inputs healthy");
  AST_DEST_GATE: assert property (
    beamPermit |-> destBeamEnable == $past(destRequest))
    else $error("Destination enable differs from request");
  AST_CHOP_HOLD: assert property (
    $fell(beamPermit) && $past(destRequest) != '0 |->
      (!beamPermit && !chopperEnable) [*8])
    else $error("Chopper or permit back too soon");
  AST_SHUT_QUIET: assert property (
    !sourceBiasEnable |-> !beamPermit && !sourceModulatorEnable
      && !transportDipoleEnable)
    else $error("Shutdown outputs disagree");
  AST_SHUT_BOUND: assert property (
    stuckRun <= 10'(SHUT_WAIT_CYC + 5))
    else $error("Sources not switched off with current present");
  AST_LOSS_TRIP: assert property (
    lossRun == 10'(LOSS_WIN_CYC) |-> ##[0:4] !beamPermit)
    else $error("Loss window did not drop the permit");
  COV_RISE: cover property ($rose(beamPermit));
  COV_SHUT: cover property ($fell(sourceBiasEnable));
  COV_LOSS: cover property (lossRun == 10'(LOSS_WIN_CYC));
endmodule : beam_permit_logic_asserts

bind beam_permit_logic beam_permit_logic_asserts #(
  .NUM_IN(NUM_IN), .NUM_DEST(NUM_DEST), .CUR_W(CUR_W)
) chk (
  .sys_clk(sys_clk), .srst(srst), .inputOk(inputOk),
  .destRequest(destRequest), .destPermit(destPermit),
  .monitorAboveLevel(monitorAboveLevel), .currentUp(currentUp),
  .currentDown(currentDown), .beamPermit(beamPermit),
  .chopperEnable(chopperEnable),
  .sourceModulatorEnable(sourceModulatorEnable),
  .transportDipoleEnable(transportDipoleEnable),
  .sourceBiasEnable(sourceBiasEnable), .destBeamEnable(destBeamEnable)
);
`default_nettype wire

// File: beam_partner.sv
`timescale 1ns/1ns
`default_nettype none
module beam_partner (
  input wire logic sys_clk,
  input wire logic [15:0] okCmd,
  input wire logic [3:0] destCmd,
  input wire logic stuck,
  input wire logic [15:0] beamUa,
  input wire logic [15:0] lossUa,
  input wire logic chopperEnable,
  input wire logic sourceBiasEnable,
  output logic [15:0] inputOk,
  output logic [3:0] destPermit,
  output logic monitorAboveLevel,
  output logic [15:0] currentUp,
  output logic [15:0] currentDown
);
  // ------
  // Providers and beam
  // ------
  logic beam;
  // Beam leaks past a stuck chopper only on command
  assign beam = sourceBiasEnable && (chopperEnable || stuck);
  always_ff @(posedge sys_clk) begin
    inputOk <= okCmd;
    destPermit <= destCmd;
    monitorAboveLevel <= beam;
    currentUp <= beam ? beamUa + lossUa : 16'h0000;
    currentDown <= beam ? beamUa : 16'h0000;
  end
endmodule : beam_partner
`default_nettype wire

// File: tb_beam_permit_logic.sv
`timescale 1ns/1ns
`default_nettype none
module tb_beam_permit_logic;
  import beam_permit_pkg::*;
  // ------
  // Bench signals
  // ------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  axil_req_s axiReq;
  axil_rsp_s axiRsp;
  logic [15:0] okCmd, inputOk, beamUa, lossUa, currentUp, currentDown;
  logic [3:0] destCmd, destRequest, destPermit, destBeamEnable;
  logic stuck, monitorAboveLevel, beamPermit, chopperEnable;
  logic [2:0] src;
  logic [31:0] rdat;
  logic [1:0] rsp;
  int failCount = 0;
  int nCompared = 0;

  always #20 sys_clk = ~sys_clk;

  beam_permit_logic #(.MAINS_CYC(100)) dut (
    .sys_clk(sys_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
    .inputOk(inputOk), .destRequest(destRequest), .destPermit(destPermit),
    .monitorAboveLevel(monitorAboveLevel), .currentUp(currentUp),
    .currentDown(currentDown), .beamPermit(beamPermit),
    .chopperEnable(chopperEnable), .sourceModulatorEnable(src[2]),
    .transportDipoleEnable(src[1]), .sourceBiasEnable(src[0]),
    .destBeamEnable(destBeamEnable)
  );
  beam_partner partner (
    .sys_clk(sys_clk), .okCmd(okCmd), .destCmd(destCmd), .stuck(stuck),
    .beamUa(beamUa), .lossUa(lossUa), .chopperEnable(chopperEnable),
    .sourceBiasEnable(src[0]), .inputOk(inputOk), .destPermit(destPermit),
    .monitorAboveLevel(monitorAboveLevel), .currentUp(currentUp),
    .currentDown(currentDown)
  );
  // ------
  // Tasks
  // ------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic check(input string nm, input logic [31:0] seen, e);
    nCompared++;
    if (seen !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  // Answers sampled at the falling edge, held through the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    axiReq.awaddr <= {24'h000000, a};
    axiReq.wdata <= d;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(negedge sys_clk);
      aw = axiRsp.awready;
      w = axiRsp.wready;
      b = axiRsp.bvalid;
      rsp = axiRsp.bresp;
      @(posedge sys_clk);
      if (aw && axiReq.awvalid) axiReq.awvalid <= 1'b0;
      if (w && axiReq.wvalid) axiReq.wvalid <= 1'b0;
    end
    check("bresp", {29'h0, !b, rsp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] m, e);
    logic ar, v;
    v = 1'b0;
    axiReq.araddr <= {24'h000000, a};
    axiReq.arvalid <= 1'b1;
    for (int n = 0; n < 100 && !v; n++) begin
      @(negedge sys_clk);
      ar = axiRsp.arready;
      v = axiRsp.rvalid;
      rdat = axiRsp.rdata;
      rsp = axiRsp.rresp;
      @(posedge sys_clk);
      if (ar) axiReq.arvalid <= 1'b0;
    end
    check(nm, v ? rdat & m : 32'hdead_beef, e);
  endtask : rd

  task automatic expP(input logic v, input int lim);
    for (int n = 0; n < lim && beamPermit !== v; n++) @(posedge sys_clk);
    check("permit", {31'h0, beamPermit}, {31'h0, v});
  endtask : expP

  task automatic hold(input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      bad = bad | (beamPermit !== v);
    end
    check("permit held", {31'h0, bad}, 32'h0);
  endtask : hold

  // Waits out the chopper phase first
  task automatic oprst();
    cyc(400);
    wr(REG_CTRL, 32'h0000_0002);
    expP(1'b1, 10);
  endtask : oprst

  task automatic finalReport();
    if (failCount == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finalReport

  initial begin
    cyc(20000);
    failCount++;
    finalReport();
  end
  // ------
  // Sequence
  // ------
  initial begin
    axiReq = '0;
    axiReq.wstrb = 4'hf;
    axiReq.bready = 1'b1;
    axiReq.rready = 1'b1;
    okCmd = 16'hffff;
    destCmd = 4'hf;
    destRequest = 4'h0;
    stuck = 1'b0;
    beamUa = 16'h03e8;
    lossUa = 16'h0000;
    cyc(8);
    srst <= 1'b0;
    cyc(2);
    rd("delay", REG_RECOVER_DELAY, '1, RECOVER_DELAY_RESET);
    rd("status", REG_STATUS, 32'h7f, 32'h0000_0004);
    rd("unmapped", 8'h40, '1, 32'h0);
    check("rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(REG_STATUS, 32'hffff_ffff);
    rd("status", REG_STATUS, 32'h7f, 32'h0000_0004);
    wr(REG_EXPECTED, 32'h0000_03e8);
    destRequest <= 4'hb;
    expP(1'b1, 10);
    check("dest", {28'h0, destBeamEnable}, 32'hb);
    destRequest <= 4'h9;
    cyc(3);
    check("dest", {27'h0, destBeamEnable, beamPermit}, 32'h13);
    okCmd[3] <= 1'b0;
    expP(1'b0, 6);
    okCmd[3] <= 1'b1;
    hold(1'b0, 420);
    rd("capture", REG_CAPTURE, 32'h8, 32'h8);
    oprst();
    destCmd[2] <= 1'b0;
    expP(1'b0, 6);
    check("dest", {28'h0, destBeamEnable}, 32'h0);
    destCmd[2] <= 1'b1;
    oprst();
    stuck <= 1'b1;
    okCmd[0] <= 1'b0;
    cyc(3);
    okCmd[0] <= 1'b1;
    cyc(360);
    check("sources", {29'h0, src}, 32'h7);
    cyc(25);
    check("sources", {29'h0, src}, 32'h0);
    rd("status", REG_STATUS, 32'h40, 32'h40);
    stuck <= 1'b0;
    oprst();
    wr(REG_SEVERE_MASK, 32'h0000_0020);
    okCmd[5] <= 1'b0;
    cyc(4);
    check("sources", {29'h0, src}, 32'h0);
    okCmd[5] <= 1'b1;
    oprst();
    wr(REG_RECOVER_MASK, 32'h0000_0080);
    wr(REG_RECOVER_DELAY, 32'h0000_0032);
    okCmd[7] <= 1'b0;
    cyc(3);
    okCmd[7] <= 1'b1;
    hold(1'b0, 350);
    expP(1'b1, 150);
    lossUa <= 16'h01f4;
    hold(1'b1, 60);
    // Leaky chopper keeps the loss going past the drop
    stuck <= 1'b1;
    lossUa <= 16'h01f5;
    expP(1'b0, 40);
    rd("status", REG_STATUS, 32'h08, 32'h08);
    cyc(30);
    lossUa <= 16'h0000;
    oprst();
    stuck <= 1'b0;
    beamUa <= 16'h04b0;
    hold(1'b1, 800);
    beamUa <= 16'h04d8;
    expP(1'b0, 20);
    rd("status", REG_STATUS, 32'h20, 32'h20);
    beamUa <= 16'h03e8;
    oprst();
    wr(REG_CTRL, 32'h0000_0001);
    lossUa <= 16'h0005;
    hold(1'b1, 250);
    lossUa <= 16'h0006;
    expP(1'b0, 250);
    // Mains fault is a one-cycle strobe, so look at the capture
    rd("capture", REG_CAPTURE, 32'h0040_0000, 32'h0040_0000);
    finalReport();
  end
endmodule : tb_beam_permit_logic
`default_nettype wire
